// *** rtl/rid_pkg.sv ***
// Package: constants and carrier types for the remote input decode and handshake block
package rid_pkg;
    localparam int NB      = 16;
    localparam int FW      = 6;
    localparam int CODE_W  = 14;
    localparam int NPARAM  = 22;
    localparam int NMS     = 6;
    // Input function codes
    localparam logic [FW-1:0] F_NONE  = 6'h00;
    localparam logic [FW-1:0] F_FWD   = 6'h01;
    localparam logic [FW-1:0] F_RVS   = 6'h02;
    localparam logic [FW-1:0] F_HOME  = 6'h03;
    localparam logic [FW-1:0] F_START = 6'h04;
    localparam logic [FW-1:0] F_SSTRT = 6'h05;
    localparam logic [FW-1:0] F_JOGP  = 6'h06;
    localparam logic [FW-1:0] F_JOGM  = 6'h07;
    localparam logic [FW-1:0] F_MS0   = 6'h08;
    localparam logic [FW-1:0] F_FREE  = 6'h0E;
    localparam logic [FW-1:0] F_CON   = 6'h0F;
    localparam logic [FW-1:0] F_STOP  = 6'h10;
    localparam logic [FW-1:0] F_ALMC  = 6'h11;
    localparam logic [FW-1:0] F_PRST  = 6'h12;
    localparam logic [FW-1:0] F_PCLR  = 6'h13;
    localparam logic [FW-1:0] F_TOOL  = 6'h14;
    localparam logic [FW-1:0] F_GF0   = 6'h15;
    localparam logic [FW-1:0] F_OD0   = 6'h25;
    localparam int            NFUNC   = 43;
    // Parameter table: 0..15 input map, 16..21 direct-position data numbers
    localparam logic [7:0] REG_MAP0   = 8'h00;
    localparam logic [7:0] REG_MS0    = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_FLAGS  = 8'h21;
    localparam int         WR_BIT     = 12;
    localparam logic [NPARAM-1:0][FW-1:0] PARAM_RESET = {
        6'h05, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00,
        F_RVS, F_FWD, F_JOGM, F_JOGP, F_SSTRT, 6'h0A, 6'h09, F_MS0,
        F_NONE, F_FREE, F_STOP, F_HOME, F_START, 6'h27, 6'h26, F_OD0};
    typedef struct packed {
        logic                  command_request_toggle;
        logic [CODE_W-1:0]     code;
        logic [3:0][7:0]       data;
    } rid_cmd_type;
    typedef struct packed {
        logic                  status;
        logic                  done;
        logic [CODE_W-1:0]     code;
        logic [3:0][7:0]       data;
    } rid_rsp_type;
    typedef struct packed {
        logic                  forward_run;
        logic                  rev;
        logic                  home_go;
        logic                  pos_go;
        logic                  seq_go;
        logic                  jogp_go;
        logic                  jogm_go;
        logic                  direct_go;
        logic [FW-1:0]         direct_no;
        logic                  free;
        logic                  excite;
        logic                  stop;
        logic                  alarm_clear;
        logic                  preset;
        logic                  tool_unlock;
        logic [NB-1:0]         general_flags;
        logic [FW-1:0]         op_data_no;
    } rid_motion_type;
endpackage

// *** rtl/rid_core.sv ***
// Remote command handshake and remote input decoder
`timescale 1ns/1ps
// Function
// - Response status bit: 0 normal completion, 1 abnormal completion.
// - Done toggle rises to 1 when command execution has finished.
// - Command executes on a 0 to 1 change of the request toggle.
// - Response echoes the command code being answered.
// - Read-back data returned little-endian, byte 0 least significant.
// - Each of sixteen input bits maps by parameter to any function or none.
// - Reset mapping follows the default function table.
// - Forward and reverse run while 1, decelerating stop at 0.
// - Start-type inputs start motion at 1, nothing at 0.
// - Direct-position inputs start positioning with their own data number.
// - Excitation release de-energises and frees brake at 1.
// - Excitation control energises at 1, de-energises at 0.
// - Halt stops motion at 1, no effect at 0.
// - Alarm clear acts only on the 1 to 0 transition.
// - Position preset acts on the 0 to 1 transition.
// - Six data-select inputs form operation data number 0 to 63.
// - Tool unlock lifts setup tool limitation while 1.
// - Sixteen general flags only hold their value.
// - Position clear unusable; unmapped bit positions ignored.
// - One function on several remote bits acts as logical OR.
// - Unmapped excitation control and tool unlock read as permanently 1.
// - Function on both direct and remote input acts as logical AND.
module rid_core
    import rid_pkg::*;
(
    input  wire logic           core_clk_i,
    input  wire logic           rst_i,
    input  wire logic [7:0]     addr_i,
    input  wire logic [15:0]    wdata_i,
    input  wire logic           wr_i,
    input  wire logic           rd_i,
    output logic [15:0]         rdata_o,
    input  wire rid_cmd_type    cmd_i,
    output rid_rsp_type         rsp_o,
    input  wire logic [NB-1:0]  remote_input_bits_i,
    input  wire logic [NFUNC-1:0] dir_in_i,
    input  wire logic [NFUNC-1:0] dir_map_i,
    output rid_motion_type      motion_o
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_DONE = 3'b100
    } rid_state_type;

    rid_state_type          state_reg, state_next;
    rid_rsp_type            rsp_reg, rsp_next;
    logic                   command_request_toggle_prev_reg, command_request_toggle_prev_next;
    logic [CODE_W-1:0]      code_reg, code_next;
    logic [3:0][7:0]        data_reg, data_next;
    logic [FW-1:0]          param_reg [NPARAM];
    logic [FW-1:0]          param_next [NPARAM];
    logic [15:0]            rdata_reg, rdata_next;
    logic [NFUNC-1:0]       eff_reg, eff_next, prev_reg, prev_next;
    logic [NFUNC-1:0]       rmap;
    rid_motion_type         motion_reg, motion_next;
    logic [7:0]             idx;
    logic                   is_wr, bad, rhit;

    // Remote command handshake and parameter table
    always_comb begin
        state_next     = state_reg;
        rsp_next       = rsp_reg;
        command_request_toggle_prev_next = cmd_i.command_request_toggle;
        code_next      = code_reg;
        data_next      = data_reg;
        rdata_next     = 16'h0000;
        for (int p = 0; p < NPARAM; p++) begin
            param_next[p] = param_reg[p];
        end
        idx   = {2'b00, code_reg[5:0]};
        is_wr = code_reg[WR_BIT];
        bad   = (code_reg[CODE_W-1:6] & ~(14'h1000 >> 6)) != '0 || idx >= 8'(NPARAM);
        if (!bad && is_wr && idx < 8'(NB) && data_reg[0][FW-1:0] >= FW'(NFUNC)) begin
            bad = 1'b1;
        end
        if (wr_i && addr_i < 8'(NPARAM)) begin
            param_next[addr_i[4:0]] = wdata_i[FW-1:0];
        end
        if (rd_i) begin
            if (addr_i < 8'(NPARAM)) begin
                rdata_next = {10'h000, param_reg[addr_i[4:0]]};
            end else if (addr_i == REG_STATUS) begin
                rdata_next = {rsp_reg.status, rsp_reg.done, 12'h000, state_reg[1], eff_reg[F_STOP]};
            end else if (addr_i == REG_FLAGS) begin
                rdata_next = eff_reg[F_GF0 +: NB];
            end
        end
        unique case (state_reg)
            ST_IDLE: begin
                if (cmd_i.command_request_toggle && !command_request_toggle_prev_reg) begin
                    code_next  = cmd_i.code;
                    data_next  = cmd_i.data;
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                rsp_next.status = bad;
                rsp_next.code   = code_reg;
                rsp_next.data   = '0;
                if (!bad && is_wr) begin
                    // Remote write beats a bus write to the same entry in this cycle
                    param_next[idx[4:0]] = data_reg[0][FW-1:0];
                end else if (!bad) begin
                    rsp_next.data[0] = {2'b00, param_reg[idx[4:0]]};
                end
                rsp_next.done = 1'b1;
                state_next    = ST_DONE;
            end
            ST_DONE: begin
                if (!cmd_i.command_request_toggle) begin
                    rsp_next.done = 1'b0;
                    state_next    = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg     <= ST_IDLE;
            rsp_reg       <= '0;
            command_request_toggle_prev_reg <= 1'b0;
            code_reg      <= '0;
            data_reg      <= '0;
            rdata_reg     <= 16'h0000;
            for (int p = 0; p < NPARAM; p++) begin
                param_reg[p] <= PARAM_RESET[p];
            end
        end else begin
            state_reg     <= state_next;
            rsp_reg       <= rsp_next;
            command_request_toggle_prev_reg <= command_request_toggle_prev_next;
            code_reg      <= code_next;
            data_reg      <= data_next;
            rdata_reg     <= rdata_next;
            for (int p = 0; p < NPARAM; p++) begin
                param_reg[p] <= param_next[p];
            end
        end
    end

    // Input decode: one effective level per function
    always_comb begin
        eff_next  = '0;
        prev_next = eff_reg;
        rmap      = '0;
        rhit      = 1'b0;
        for (int f = 0; f < NFUNC; f++) begin
            rhit = 1'b0;
            for (int b = 0; b < NB; b++) begin
                if (param_reg[b] == FW'(f)) begin
                    rmap[f] = 1'b1;
                    rhit    = rhit | remote_input_bits_i[b];
                end
            end
            if (rmap[f] && dir_map_i[f]) begin
                eff_next[f] = rhit & dir_in_i[f];
            end else if (rmap[f]) begin
                eff_next[f] = rhit;
            end else if (dir_map_i[f]) begin
                eff_next[f] = dir_in_i[f];
            end else begin
                eff_next[f] = (FW'(f) == F_CON) || (FW'(f) == F_TOOL);
            end
        end
        // Unused positions land on code zero and are dropped here
        eff_next[F_NONE] = 1'b0;
        eff_next[F_PCLR] = 1'b0;
    end

    // Motion requests; start-type outputs are one-cycle pulses on a rising level
    always_comb begin
        motion_next             = '0;
        motion_next.forward_run         = eff_reg[F_FWD];
        motion_next.rev         = eff_reg[F_RVS];
        motion_next.home_go     = eff_reg[F_HOME] & ~prev_reg[F_HOME];
        motion_next.pos_go      = eff_reg[F_START] & ~prev_reg[F_START];
        motion_next.seq_go      = eff_reg[F_SSTRT] & ~prev_reg[F_SSTRT];
        motion_next.jogp_go     = eff_reg[F_JOGP] & ~prev_reg[F_JOGP];
        motion_next.jogm_go     = eff_reg[F_JOGM] & ~prev_reg[F_JOGM];
        motion_next.direct_no   = motion_reg.direct_no;
        // Lowest-numbered direct input wins when several rise together
        for (int m = NMS - 1; m >= 0; m--) begin
            if (eff_reg[F_MS0 + m] && !prev_reg[F_MS0 + m]) begin
                motion_next.direct_go = 1'b1;
                motion_next.direct_no = param_reg[NB + m];
            end
        end
        motion_next.free        = eff_reg[F_FREE];
        motion_next.excite      = eff_reg[F_CON];
        motion_next.stop        = eff_reg[F_STOP];
        motion_next.alarm_clear = prev_reg[F_ALMC] & ~eff_reg[F_ALMC];
        motion_next.preset      = eff_reg[F_PRST] & ~prev_reg[F_PRST];
        motion_next.tool_unlock = eff_reg[F_TOOL];
        motion_next.general_flags = eff_reg[F_GF0 +: NB];
        motion_next.op_data_no  = eff_reg[F_OD0 +: FW];
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            eff_reg    <= '0;
            prev_reg   <= '0;
            motion_reg <= '0;
        end else begin
            eff_reg    <= eff_next;
            prev_reg   <= prev_next;
            motion_reg <= motion_next;
        end
    end

    assign rdata_o  = rdata_reg;
    assign rsp_o    = rsp_reg;
    assign motion_o = motion_reg;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_command_request_toggle_rise;
        state_reg == ST_IDLE && cmd_i.command_request_toggle && !command_request_toggle_prev_reg;
    endsequence
    sequence s_answer;
        state_reg == ST_EXEC ##1 (rsp_reg.done && state_reg == ST_DONE);
    endsequence

    a_command_request_toggle_starts_exec: assert property (s_command_request_toggle_rise |=> s_answer)
        else $error("request edge did not lead to completion");
    a_done_stays_low: assert property (state_reg == ST_IDLE |-> !rsp_reg.done)
        else $error("done high while idle");
    a_done_clears: assert property (rsp_reg.done && !cmd_i.command_request_toggle |=> !rsp_reg.done)
        else $error("done not cleared after request dropped");
    a_code_echoed: assert property ($rose(rsp_reg.done) |-> rsp_reg.code == $past(code_reg))
        else $error("response code differs from command");
    a_status_flag: assert property (state_reg == ST_EXEC |=> rsp_reg.status == $past(bad))
        else $error("status bit wrong");
    a_alarm_fall: assert property (prev_reg[F_ALMC] && !eff_reg[F_ALMC]
        |=> motion_reg.alarm_clear)
        else $error("alarm clear missed on falling input");
    a_alarm_no_rise: assert property (!prev_reg[F_ALMC] && eff_reg[F_ALMC]
        |=> !motion_reg.alarm_clear)
        else $error("alarm clear on rising input");
    a_preset_rise: assert property ($rose(eff_reg[F_PRST]) |=> motion_reg.preset)
        else $error("preset missed on rising input");
    a_excite_default: assert property (!rmap[F_CON] && !dir_map_i[F_CON]
        |=> ##1 motion_reg.excite)
        else $error("unmapped excitation control not held on");
    a_pclr_dead: assert property (!eff_reg[F_PCLR])
        else $error("position clear became active");
    a_read_window: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("read data outside its cycle");

    // Handshake steps, the response word and bus access to the table
    a_exec_one_cycle: assert property (state_reg == ST_EXEC
        |=> state_reg == ST_DONE)
        else $error("execution took more than one cycle");
    a_done_holds: assert property (rsp_reg.done && cmd_i.command_request_toggle
        |=> rsp_reg.done)
        else $error("done dropped while request still high");
    a_no_retake: assert property (state_reg == ST_DONE && cmd_i.command_request_toggle
        |=> state_reg == ST_DONE)
        else $error("left done state with request high");
    a_read_data_le: assert property (state_reg == ST_EXEC && !bad && !is_wr
        |=> rsp_reg.data[0] == {2'b00, $past(param_reg[idx[4:0]])} && rsp_reg.data[3:1] == '0)
        else $error("read-back data not in low byte");
    a_bad_no_data: assert property (state_reg == ST_EXEC && bad
        |=> rsp_reg.data == '0)
        else $error("refused command returned data");
    a_remote_write: assert property (state_reg == ST_EXEC && !bad && is_wr
        |=> param_reg[$past(idx[4:0])] == $past(data_reg[0][FW-1:0]))
        else $error("remote write did not land");
    a_bus_read: assert property (rd_i && addr_i < 8'(NPARAM)
        |=> rdata_o == {10'h000, $past(param_reg[addr_i[4:0]])})
        else $error("bus read of table wrong");
    a_bus_write: assert property (wr_i && addr_i < 8'(NPARAM)
        && !(state_reg == ST_EXEC && is_wr && !bad && idx == addr_i)
        |=> param_reg[$past(addr_i[4:0])] == $past(wdata_i[FW-1:0]))
        else $error("bus write did not land");

    // Input decode
    a_or_merge: assert property (param_reg[7] == F_FWD && remote_input_bits_i[7]
        && !dir_map_i[F_FWD] |=> eff_reg[F_FWD])
        else $error("shared function not merged by OR");
    a_and_both: assert property (rmap[F_FWD] && dir_map_i[F_FWD] && !dir_in_i[F_FWD]
        |=> !eff_reg[F_FWD])
        else $error("direct and remote not merged by AND");
    a_unused_bit: assert property (!eff_reg[F_NONE])
        else $error("unused position became active");
    a_unmapped_low: assert property (!rmap[F_PRST] && !dir_map_i[F_PRST]
        |=> !eff_reg[F_PRST])
        else $error("unmapped function active");
    a_tool_default: assert property (!rmap[F_TOOL] && !dir_map_i[F_TOOL]
        |=> ##1 motion_reg.tool_unlock)
        else $error("unmapped tool unlock not held on");

    // Level outputs follow their effective inputs one cycle later
    a_fwd_level: assert property (eff_reg[F_FWD] |=> motion_reg.forward_run)
        else $error("forward run missing");
    a_fwd_stop: assert property (!eff_reg[F_FWD] |=> !motion_reg.forward_run)
        else $error("forward run not stopped");
    a_rev_level: assert property (eff_reg[F_RVS] |=> motion_reg.rev)
        else $error("reverse run missing");
    a_rev_stop: assert property (!eff_reg[F_RVS] |=> !motion_reg.rev)
        else $error("reverse run not stopped");
    a_free_follow: assert property (1'b1 |=> motion_reg.free == $past(eff_reg[F_FREE]))
        else $error("excitation release wrong");
    a_excite_follow: assert property (1'b1 |=> motion_reg.excite == $past(eff_reg[F_CON]))
        else $error("excitation control wrong");
    a_stop_follow: assert property (1'b1 |=> motion_reg.stop == $past(eff_reg[F_STOP]))
        else $error("halt wrong");
    a_tool_follow: assert property (1'b1
        |=> motion_reg.tool_unlock == $past(eff_reg[F_TOOL]))
        else $error("tool unlock wrong");
    a_flags_follow: assert property (1'b1
        |=> motion_reg.general_flags == $past(eff_reg[F_GF0 +: NB]))
        else $error("general flags wrong");
    a_opdata_follow: assert property (1'b1
        |=> motion_reg.op_data_no == $past(eff_reg[F_OD0 +: FW]))
        else $error("operation data number wrong");

    // Start-type, preset and alarm clear pulses
    a_home_pulse: assert property (eff_reg[F_HOME] && !prev_reg[F_HOME]
        |=> motion_reg.home_go)
        else $error("return-to-origin start missed");
    a_home_quiet: assert property (!eff_reg[F_HOME] |=> !motion_reg.home_go)
        else $error("return-to-origin started at 0");
    a_start_pulse: assert property (eff_reg[F_START] && !prev_reg[F_START]
        |=> motion_reg.pos_go)
        else $error("positioning start missed");
    a_start_quiet: assert property (!eff_reg[F_START] |=> !motion_reg.pos_go)
        else $error("positioning started at 0");
    a_seq_pulse: assert property (eff_reg[F_SSTRT] && !prev_reg[F_SSTRT]
        |=> motion_reg.seq_go)
        else $error("sequential start missed");
    a_seq_quiet: assert property (!eff_reg[F_SSTRT] |=> !motion_reg.seq_go)
        else $error("sequential started at 0");
    a_jogp_pulse: assert property (eff_reg[F_JOGP] && !prev_reg[F_JOGP]
        |=> motion_reg.jogp_go)
        else $error("jog plus missed");
    a_jogm_pulse: assert property (eff_reg[F_JOGM] && !prev_reg[F_JOGM]
        |=> motion_reg.jogm_go)
        else $error("jog minus missed");
    a_jog_quiet: assert property (!eff_reg[F_JOGP] && !eff_reg[F_JOGM]
        |=> !motion_reg.jogp_go && !motion_reg.jogm_go)
        else $error("jog started at 0");
    a_direct_number: assert property (eff_reg[F_MS0 + 1] && !prev_reg[F_MS0 + 1]
        && !(eff_reg[F_MS0] && !prev_reg[F_MS0])
        |=> motion_reg.direct_go && motion_reg.direct_no == $past(param_reg[NB + 1]))
        else $error("direct position used wrong data number");
    a_direct_quiet: assert property ((eff_reg[F_MS0 +: NMS] & ~prev_reg[F_MS0 +: NMS]) == '0
        |=> !motion_reg.direct_go)
        else $error("direct position started without edge");
    a_preset_quiet: assert property (!eff_reg[F_PRST] |=> !motion_reg.preset)
        else $error("preset without input");
    a_alarm_quiet: assert property (eff_reg[F_ALMC] |=> !motion_reg.alarm_clear)
        else $error("alarm clear while input high");
endmodule

// *** tb/rid_master.sv ***
// Network converter model: drives the remote command handshake as bus master
`timescale 1ns/1ps
module rid_master
    import rid_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire rid_rsp_type rsp_i,
    output rid_cmd_type      cmd_o
);
    initial cmd_o = '0;
    // One command; slow idles first so both prompt and lazy masters are seen
    task automatic run(input logic [CODE_W-1:0] code, input logic [31:0] data,
                       input int slow, output rid_rsp_type r, output logic ok);
        int n;
        ok = 1'b0;
        repeat (slow) @(posedge core_clk_i);
        cmd_o <= rid_cmd_type'({1'b1, code, data});
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge core_clk_i);
            ok = rsp_i.done;
        end
        r = rsp_i;
        // Released fields carry junk so a late sample of them shows up
        cmd_o <= rid_cmd_type'({1'b0, ~code, ~data});
        for (n = 0; n < 20 && rsp_i.done; n++) begin
            @(posedge core_clk_i);
        end
        ok = ok & ~rsp_i.done;
    endtask
endmodule

// *** tb/rid_core_bench.sv ***
// Self-checking bench for the remote input decode and handshake block
`timescale 1ns/1ps
module rid_core_bench;
    import rid_pkg::*;
    logic             clk = 1'b0;
    logic             rst_i = 1'b1;
    logic [7:0]       addr_i = '0;
    logic [15:0]      wdata_i = '0;
    logic [15:0]      rdata_o;
    logic             wr_i = 1'b0;
    logic             rd_i = 1'b0;
    rid_cmd_type      cmd;
    rid_rsp_type      rsp;
    rid_rsp_type      r;
    logic [NB-1:0]    rib = '0;
    logic [NFUNC-1:0] din = '0;
    logic [NFUNC-1:0] dmap = '0;
    rid_motion_type   mo;
    logic [7:0]       pl;
    int               pc [8];
    int               n_errors = 0;
    int               checks = 0;
    int               cyc = 0;
    logic             ok;
    logic [15:0]      d;
    logic [FW-1:0]    dm [16] = '{F_OD0, 6'h26, 6'h27, F_START, F_HOME, F_STOP, F_FREE,
        F_NONE, F_MS0, 6'h09, 6'h0A, F_SSTRT, F_JOGP, F_JOGM, F_FWD, F_RVS};
    int               pb [5] = '{4, 3, 11, 12, 13};

    rid_core uut (.core_clk_i(clk), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmd_i(cmd), .rsp_o(rsp),
        .remote_input_bits_i(rib), .dir_in_i(din), .dir_map_i(dmap), .motion_o(mo));
    rid_master mst (.core_clk_i(clk), .rsp_i(rsp), .cmd_o(cmd));

    always #20 clk = ~clk;
    assign pl = {mo.home_go, mo.pos_go, mo.seq_go, mo.jogp_go, mo.jogm_go,
                 mo.direct_go, mo.alarm_clear, mo.preset};
    // Pulses are one cycle wide, so they are counted rather than sampled
    always @(posedge clk) begin
        for (int i = 0; i < 8; i++) pc[i] += int'(pl[i]);
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            wrap_up;
        end
    end

    task automatic wrap_up;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic bw(input logic [7:0] a, input logic [15:0] v);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk);
        wr_i <= 1'b0;
        @(posedge clk);
    endtask
    task automatic br(input logic [7:0] a);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk);
        rd_i <= 1'b0;
        @(posedge clk);
        d = rdata_o;
    endtask
    task automatic st;
        repeat (4) @(posedge clk);
    endtask
    task automatic rc(input logic [CODE_W-1:0] c, input logic [31:0] v, input int s,
                      input logic es, input logic [31:0] e);
        mst.run(c, v, s, r, ok);
        chk({31'h0, ok}, 32'h1);
        chk({31'h0, r.status}, {31'h0, es});
        chk({18'h0, r.code}, {18'h0, c});
        if (!c[12]) chk(r.data, e);
    endtask

    task automatic t_reset;
        for (int i = 0; i < 16; i++) begin
            br(8'(i));
            chk({16'h0, d}, {26'h0, dm[i]});
        end
        for (int i = 0; i < NMS; i++) begin
            br(REG_MS0 + 8'(i));
            chk({16'h0, d}, 32'(i));
        end
        br(8'h30);
        chk({16'h0, d}, 32'h0);
        chk({30'h0, mo.excite, mo.tool_unlock}, 32'h3);
        $display("reset test done");
    endtask
    task automatic t_cmd;
        rc(14'h0003, 32'hA5A5A5A5, 0, 1'b0, 32'h04);
        rc(14'h1007, 32'h12, 2, 1'b0, 32'h0);
        br(8'h07);
        chk({16'h0, d}, 32'h12);
        rc(14'h0007, 32'h0, 0, 1'b0, 32'h12);
        rc(14'h1007, 32'h3F, 0, 1'b1, 32'h0);
        rc(14'h2003, 32'h0, 1, 1'b1, 32'h0);
        br(8'h07);
        chk({16'h0, d}, 32'h12);
        bw(8'h07, 16'h0000);
        $display("command test done");
    endtask
    task automatic t_level;
        rib <= 16'h4025;
        st;
        chk({mo.forward_run, mo.rev, mo.stop, mo.free, 2'b0, mo.op_data_no}, 12'hA05);
        br(REG_STATUS);
        chk({16'h0, d}, 32'h8001);
        rib <= 16'h8042;
        st;
        chk({mo.forward_run, mo.rev, mo.stop, mo.free, 2'b0, mo.op_data_no}, 12'h502);
        bw(8'h07, 16'(F_FWD));
        rib <= 16'h0080;
        st;
        chk({31'h0, mo.forward_run}, 32'h1);
        dmap[F_FWD] <= 1'b1;
        st;
        chk({31'h0, mo.forward_run}, 32'h0);
        din[F_FWD] <= 1'b1;
        st;
        chk({31'h0, mo.forward_run}, 32'h1);
        dmap <= '0;
        rib <= '0;
        bw(8'h07, 16'(F_CON));
        st;
        chk({31'h0, mo.excite}, 32'h0);
        rib <= 16'h0080;
        st;
        chk({31'h0, mo.excite}, 32'h1);
        rib <= '0;
        bw(8'h07, 16'(F_TOOL));
        st;
        chk({31'h0, mo.tool_unlock}, 32'h0);
        bw(8'h07, 16'(F_GF0 + 6'd3));
        rib <= 16'h0080;
        st;
        chk({16'h0, mo.general_flags}, 32'h0008);
        br(REG_FLAGS);
        chk({16'h0, d}, 32'h0008);
        bw(8'h07, 16'(F_PCLR));
        st;
        chk({mo.general_flags, 14'h0, mo.excite, mo.tool_unlock}, 32'h3);
        rib <= '0;
        bw(8'h07, 16'h0000);
        $display("level test done");
    endtask
    task automatic t_pulse;
        for (int k = 0; k < 5; k++) begin
            pc[7 - k] = 0;
            rib <= 16'(1) << pb[k];
            st;
            chk(32'(pc[7 - k]), 32'h1);
            rib <= '0;
            st;
            chk(32'(pc[7 - k]), 32'h1);
        end
        bw(8'h07, 16'(F_ALMC));
        pc[1] = 0;
        rib <= 16'h0080;
        st;
        chk(32'(pc[1]), 32'h0);
        rib <= '0;
        st;
        chk(32'(pc[1]), 32'h1);
        bw(8'h07, 16'(F_PRST));
        pc[0] = 0;
        rib <= 16'h0080;
        st;
        chk(32'(pc[0]), 32'h1);
        rib <= '0;
        st;
        chk(32'(pc[0]), 32'h1);
        bw(REG_MS0 + 8'h01, 16'd42);
        pc[2] = 0;
        rib <= 16'h0200;
        st;
        chk({26'h0, mo.direct_no}, 32'd42);
        chk(32'(pc[2]), 32'h1);
        rib <= '0;
        $display("pulse test done");
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_i <= 1'b0;
        @(posedge clk);
        t_reset;
        t_cmd;
        t_level;
        t_pulse;
        wrap_up;
    end
endmodule
